// file: hw/port_regs_defs.svh
// Function
// R1: writing one to power bit turns slot off
// R2: power bit zero drives slot powered on
// R3: enable bit gates link-active change notification
// R4: link status bit 29 shows link active
// R5: attention press latches, cleared by write one
// R6: power fault latches, write one clears
// R7: latch sensor change flag, read only
// R8: presence change latches, write one clears
// R9: command completion latches, write one clears
// R10: latch sensor state shown live
// R11: presence state; reads one without slot (code does so on downstream ports only; upstream reads the pin)
// R12: link-active change latches, write one clears
// R13: latency reporting advertised, enable bit writable
// R14: flush/fill hint field writable, resets zero
// R15: de-emphasis bit read only, port-type reset
// R16: error header id, version, next pointer
// R17: uncorrectable events latch, write one clears
// R18: poisoned packet received or generated latches
// R19: malformed, crc, unsupported, access violation latch
// R20: masked errors not logged nor reported
// R21: severity bits select fatal or non-fatal
// R22: reserved fields read zero, ignore writes
`ifndef PORT_REGS_DEFS_SVH
`define PORT_REGS_DEFS_SVH
`define ADR_LINK_STS   12'h0D0
`define ADR_SLOT       12'h0D8
`define ADR_DEV_CAP2   12'h0E4
`define ADR_DEV_CTL2   12'h0E8
`define ADR_LINK_CAP2  12'h0EC
`define ADR_LINK_CTL2  12'h0F0
`define ADR_SLOT_CAP2  12'h0F4
`define ADR_SLOT_CTL2  12'h0F8
`define ADR_AER_HDR    12'h100
`define ADR_UE_STS     12'h104
`define ADR_UE_MASK    12'h108
`define ADR_UE_SEV     12'h10C
`define LINK_ACT_BIT   29
`define SLOT_W1C_MASK  16'h011B
`define DEV_CAP2_VAL   32'h00000800
`define AER_HDR_VAL    32'h14010001
`define UE_IMPL_MASK   32'h003FF011
`define UE_SEV_RESET   32'h00062011
`define UE_POISON_BIT  12
`define LCTL2_RW_MASK  16'h1FBF
`define LCTL2_RESET    16'h0002
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// file: hw/port_regs_pkg.sv
package port_regs_pkg;
    // upper slot control bits held by this bank
    typedef struct packed {
        logic dll_notify_en;  // bit 12
        logic em_lock;        // bit 11
        logic power_off;      // bit 10
    } slot_ctl_t;
    // writable device control 2 fields
    typedef struct packed {
        logic [1:0] obff;     // bits 14:13
        logic       ltr_en;   // bit 10
    } dev_ctl2_t;
endpackage

// file: hw/pcie_port_slot_aer_regs.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "port_regs_defs.svh"
module pcie_port_slot_aer_regs (
    input  wire logic        aclk,                     // port clock
    input  wire logic        aresetn,                  // sync reset, low
    input  wire logic [11:0] awaddr,                   // write address
    input  wire logic        awvalid,                  // write addr valid
    output logic             awready,                  // write addr ready
    input  wire logic [31:0] wdata,                    // write data
    input  wire logic [3:0]  wstrb,                    // byte enables
    input  wire logic        wvalid,                   // write data valid
    output logic             wready,                   // write data ready
    output logic [1:0]       bresp,                    // write response
    output logic             bvalid,                   // response valid
    input  wire logic        bready,                   // response ready
    input  wire logic [11:0] araddr,                   // read address
    input  wire logic        arvalid,                  // read addr valid
    output logic             arready,                  // read addr ready
    output logic [31:0]      rdata,                    // read data
    output logic [1:0]       rresp,                    // read response
    output logic             rvalid,                   // read data valid
    input  wire logic        rready,                   // read data ready
    input  wire logic        attn_button_pin,          // button pressed
    input  wire logic        power_fault_pin,          // power fault
    input  wire logic        mrl_open_pin,             // latch opened
    input  wire logic        card_present_pin,         // card in slot
    input  wire logic        command_done,             // hp command pulse
    input  wire logic        link_layer_active_state,  // link active
    input  wire logic        port_is_downstream,       // port type
    input  wire logic        slot_implemented,         // slot present
    input  wire logic [31:0] err_events,               // error pulses
    input  wire logic        poisoned_rx,              // poisoned in
    input  wire logic        poisoned_gen,             // poisoned out
    output logic             slot_power_off,           // power ctl off
    output logic             electromech_lock_control, // lock control
    output logic             dll_change_notify,        // notify pulse
    output logic             ltr_enable,               // latency enable
    output logic [1:0]       obff_enable,              // hint method
    output logic             autonomous_speed_disable, // speed ctl
    output logic             err_fatal_msg,            // fatal report
    output logic             err_nonfatal_msg,         // non-fatal report
    output logic             header_log_capture        // log capture
);

    // bus handshake state
    logic        aw_got_ff, w_got_ff, bvalid_ff, awready_ff, wready_ff;
    logic        arready_ff, rvalid_ff;
    logic [11:0] waddr_ff;          // aligned write address
    logic [31:0] wdata_ff;          // held write data
    logic [3:0]  wstrb_ff;          // held byte enables
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic        nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
    logic        do_write;          // both halves held, commit now
    logic [31:0] wbits;             // byte enables as bit mask
    logic [31:0] rd_word;           // read mux result
    // register state
    port_regs_pkg::slot_ctl_t slot_ctl_ff;
    port_regs_pkg::dev_ctl2_t dev_ctl2_ff;
    logic [15:0] slot_sts_ff;       // slot status, bits 31:16
    logic [15:0] link_ctl2_ff;      // link control 2 store
    logic [31:0] ue_sts_ff, ue_mask_ff, ue_sev_ff;
    logic        link_act_ff;       // last link active value
    logic        ds_ff, slot_impl_ff;
    logic        notify_ff, fatal_ff, nonfatal_ff, log_ff;
    // pin synchronisers: attn, fault, mrl, presence
    logic [3:0]  hp_s1_ff, hp_s2_ff, hp_d_ff;
    logic [15:0] slot_set;          // hardware set terms
    logic [31:0] ue_ev;             // implemented error events
    logic [31:0] ue_live;           // unmasked error events
    logic        dll_chg;           // link active changed
    logic        presence_rd;       // presence bit as read

    // expand byte enables to a bit mask
    function automatic logic [31:0] strb_bits(input logic [3:0] s);
        strb_bits = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // true for every word this bank answers
    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `ADR_LINK_STS, `ADR_SLOT, `ADR_DEV_CAP2, `ADR_DEV_CTL2,
            `ADR_LINK_CAP2, `ADR_LINK_CTL2, `ADR_SLOT_CAP2,
            `ADR_SLOT_CTL2, `ADR_AER_HDR, `ADR_UE_STS, `ADR_UE_MASK,
            `ADR_UE_SEV: is_mapped = 1'b1;
            default:     is_mapped = 1'b0;
        endcase
    endfunction

    // merge writable bits under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] rw);
        merge = (old & ~(rw & wbits)) | (wdata_ff & rw & wbits);
    endfunction

    assign wbits    = strb_bits(wstrb_ff);
    assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;

    // next-state of write and read channels
    always_comb begin
        nxt_aw_got = aw_got_ff ? ~do_write : (awvalid & awready_ff);
        nxt_w_got  = w_got_ff ? ~do_write : (wvalid & wready_ff);
        nxt_bvalid = do_write | (bvalid_ff & ~bready);
        nxt_rvalid = (arvalid & arready_ff) | (rvalid_ff & ~rready);
    end

    // write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            waddr_ff   <= 12'h000;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
        end else begin
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
            if (awvalid && awready_ff) begin
                waddr_ff <= {awaddr[11:2], 2'h0};
            end
            if (wvalid && wready_ff) begin
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
        end
    end

    // write response, error for unmapped words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RESP_OKAY;
        end else begin
            bvalid_ff <= nxt_bvalid;
            if (do_write) begin
                bresp_ff <= is_mapped(waddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // read mux; unlisted bits read zero (see R22)
    always_comb begin
        rd_word = 32'h00000000;
        case ({araddr[11:2], 2'h0})
            `ADR_LINK_STS: rd_word[`LINK_ACT_BIT] = link_act_ff; // see R4
            `ADR_SLOT: rd_word = {slot_sts_ff | {9'h000, presence_rd,
                                  hp_d_ff[2], 5'h00},          // see R10
                                  3'h0, slot_ctl_ff, 10'h000};
            `ADR_DEV_CAP2: rd_word = `DEV_CAP2_VAL;            // see R13
            `ADR_DEV_CTL2: rd_word = {17'h00000, dev_ctl2_ff.obff, 2'h0,
                                      dev_ctl2_ff.ltr_en, 10'h000};
            `ADR_LINK_CTL2: rd_word = {15'h0000, ds_ff, link_ctl2_ff[15:7],
                                       ds_ff, link_ctl2_ff[5:0]}; // see R15
            `ADR_AER_HDR: rd_word = `AER_HDR_VAL;              // see R16
            `ADR_UE_STS:  rd_word = ue_sts_ff;
            `ADR_UE_MASK: rd_word = ue_mask_ff;
            `ADR_UE_SEV:  rd_word = ue_sev_ff;
            default:      rd_word = 32'h00000000;
        endcase
    end

    // read channel: data captured at address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= `RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (arvalid && arready_ff) begin
                rdata_ff <= rd_word;
                rresp_ff <= is_mapped({araddr[11:2], 2'h0}) ?
                            `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // hot-plug pins pass two flops, third stage for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hp_s1_ff <= 4'h0;
            hp_s2_ff <= 4'h0;
            hp_d_ff  <= 4'h0;
        end else begin
            hp_s1_ff <= {card_present_pin, mrl_open_pin,
                         power_fault_pin, attn_button_pin};
            hp_s2_ff <= hp_s1_ff;
            hp_d_ff  <= hp_s2_ff;
        end
    end

    // static port straps and link active history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ds_ff        <= 1'b0;
            slot_impl_ff <= 1'b0;
            link_act_ff  <= 1'b0;
        end else begin
            ds_ff        <= port_is_downstream;
            slot_impl_ff <= slot_implemented;
            link_act_ff  <= link_layer_active_state;
        end
    end

    assign dll_chg     = link_layer_active_state ^ link_act_ff;
    // no slot on a downstream port: presence reads one (see R11)
    assign presence_rd = (ds_ff & ~slot_impl_ff) | hp_d_ff[3];
    assign slot_set = {7'h00, dll_chg,                       // see R12
                       3'h0, command_done,                   // see R9
                       hp_s2_ff[3] ^ hp_d_ff[3],             // see R8
                       hp_s2_ff[2] ^ hp_d_ff[2],             // see R7
                       hp_s2_ff[1] & ~hp_d_ff[1],            // see R6
                       hp_s2_ff[0] & ~hp_d_ff[0]};           // see R5

    // slot status flags: set wins over write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_sts_ff <= 16'h0000;
        end else if (do_write && waddr_ff == `ADR_SLOT) begin
            slot_sts_ff <= (slot_sts_ff & ~(wdata_ff[31:16] &
                           wbits[31:16] & `SLOT_W1C_MASK)) | slot_set;
        end else begin
            slot_sts_ff <= slot_sts_ff | slot_set;
        end
    end

    // upper slot control bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_ctl_ff <= '0;
        end else if (do_write && waddr_ff == `ADR_SLOT && wstrb_ff[1]) begin
            slot_ctl_ff <= wdata_ff[12:10];                  // see R1, R2
        end
    end

    // device control 2 and link control 2 writable fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dev_ctl2_ff  <= '0;                              // see R14
            link_ctl2_ff <= `LCTL2_RESET;
        end else if (do_write) begin
            if (waddr_ff == `ADR_DEV_CTL2) begin
                if (wstrb_ff[1]) begin
                    dev_ctl2_ff.ltr_en <= wdata_ff[10];      // see R13
                    dev_ctl2_ff.obff   <= wdata_ff[14:13];   // see R14
                end
            end
            if (waddr_ff == `ADR_LINK_CTL2) begin
                link_ctl2_ff <= 16'(merge({16'h0000, link_ctl2_ff},
                                {16'h0000, `LCTL2_RW_MASK}));
            end
        end
    end

    // implemented events; poisoned seen either way (see R18)
    assign ue_ev = (err_events | ({31'h00000000, poisoned_rx | poisoned_gen}
                    << `UE_POISON_BIT)) & `UE_IMPL_MASK;     // see R19
    assign ue_live = ue_ev & ~ue_mask_ff;                    // see R20

    // error status: set wins over write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ue_sts_ff <= 32'h00000000;
        end else if (do_write && waddr_ff == `ADR_UE_STS) begin
            ue_sts_ff <= (ue_sts_ff & ~(wdata_ff & wbits)) | ue_ev;
        end else begin
            ue_sts_ff <= ue_sts_ff | ue_ev;                  // see R17
        end
    end

    // error mask and severity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ue_mask_ff <= 32'h00000000;
            ue_sev_ff  <= `UE_SEV_RESET;                     // see R21
        end else if (do_write) begin
            if (waddr_ff == `ADR_UE_MASK) begin
                ue_mask_ff <= merge(ue_mask_ff, `UE_IMPL_MASK);
            end
            if (waddr_ff == `ADR_UE_SEV) begin
                ue_sev_ff <= merge(ue_sev_ff, `UE_IMPL_MASK);
            end
        end
    end

    // report pulses toward the message and log logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            notify_ff   <= 1'b0;
            fatal_ff    <= 1'b0;
            nonfatal_ff <= 1'b0;
            log_ff      <= 1'b0;
        end else begin
            notify_ff   <= dll_chg & slot_ctl_ff.dll_notify_en; // see R3
            fatal_ff    <= |(ue_live & ue_sev_ff);           // see R21
            nonfatal_ff <= |(ue_live & ~ue_sev_ff);
            log_ff      <= |ue_live;                         // see R20
        end
    end

    assign awready   = awready_ff;
    assign wready    = wready_ff;
    assign bvalid    = bvalid_ff;
    assign bresp     = bresp_ff;
    assign arready   = arready_ff;
    assign rvalid    = rvalid_ff;
    assign rdata     = rdata_ff;
    assign rresp     = rresp_ff;
    assign slot_power_off           = slot_ctl_ff.power_off;
    assign electromech_lock_control = slot_ctl_ff.em_lock;
    assign dll_change_notify        = notify_ff;
    assign ltr_enable               = dev_ctl2_ff.ltr_en;
    assign obff_enable              = dev_ctl2_ff.obff;
    assign autonomous_speed_disable = link_ctl2_ff[5];
    assign err_fatal_msg            = fatal_ff;
    assign err_nonfatal_msg         = nonfatal_ff;
    assign header_log_capture       = log_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // both halves held, then commit
    sequence s_wr_commit;
        do_write && waddr_ff == `ADR_SLOT && wstrb_ff[1];
    endsequence
    // address taken at a handshake
    sequence s_rd_link;
        arvalid && arready_ff && {araddr[11:2], 2'h0} == `ADR_LINK_STS;
    endsequence

    a_power_ctl_write: assert property (s_wr_commit |=>       // see R1
        slot_power_off == $past(wdata_ff[10]) && bvalid)
        else $error("power control bit not taken from write");
    a_notify_gate: assert property (dll_chg |=>                // see R3
        dll_change_notify == $past(slot_ctl_ff.dll_notify_en))
        else $error("link change notify wrong");
    a_link_active_read: assert property (s_rd_link |=>         // see R4
        rvalid && rdata[`LINK_ACT_BIT] == $past(link_act_ff))
        else $error("link active read wrong");
    a_attn_latch: assert property (attn_button_pin[*3] ##1
        !$past(hp_d_ff[0]) |-> slot_sts_ff[0])               // see R5
        else $error("attention press not latched");
    a_dll_flag_set: assert property (dll_chg |=> slot_sts_ff[8]) // see R12
        else $error("link change flag lost");
    a_ue_latch: assert property (ue_ev != 32'h00000000 |=>    // see R17
        (ue_sts_ff & $past(ue_ev)) == $past(ue_ev))
        else $error("error event not latched");
    a_mask_blocks: assert property ((ue_ev & ~ue_mask_ff) == 32'h00000000
        |=> !err_fatal_msg && !err_nonfatal_msg && !header_log_capture)
        else $error("masked error reported");                 // see R20
    a_fatal_class: assert property (ue_live[0] && ue_sev_ff[0]
        |=> err_fatal_msg) else $error("fatal not reported"); // see R21
    a_wr_answer: assert property (do_write
        |=> bvalid ##1 (bvalid || $past(bready)))
        else $error("write response dropped");

endmodule // pcie_port_slot_aer_regs

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        aclk, aresetn;            // clock, sync reset
    logic [11:0] awaddr, araddr;           // bus addresses
    logic [31:0] wdata, rdata, err_events; // bus data, error pulses
    logic [3:0]  wstrb;                    // byte enables
    logic [1:0]  bresp, rresp, rsp;        // responses
    logic [31:0] rd;                       // read word
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic attn_button_pin, power_fault_pin, mrl_open_pin, card_present_pin;
    logic command_done, link_layer_active_state, port_is_downstream;
    logic slot_implemented, poisoned_rx, poisoned_gen;
    logic slot_power_off, electromech_lock_control, dll_change_notify;
    logic ltr_enable, autonomous_speed_disable;
    logic [1:0] obff_enable;
    logic err_fatal_msg, err_nonfatal_msg, header_log_capture;
    int   err_total, check_count;          // mismatches, compares
    int   n_note, n_fatal, n_nonfat, n_log; // pulse cycle counts
    typedef struct {
        logic [11:0] a;    // address
        bit          wr;   // write before reading
        logic [31:0] d;    // write data
        logic [31:0] exp;  // expected read data
        logic [1:0]  r;    // expected response
    } row_t;
    // reset values, then all-ones writes against access kinds
    row_t rows [22] = '{
        '{12'h0D0,0,0,32'h0,2'h0}, '{12'h0D8,0,0,32'h0,2'h0},
        '{12'h0E4,0,0,32'h800,2'h0}, '{12'h0E8,0,0,32'h0,2'h0},
        '{12'h0EC,0,0,32'h0,2'h0}, '{12'h0F0,0,0,32'h00010042,2'h0},
        '{12'h0F4,0,0,32'h0,2'h0}, '{12'h0F8,0,0,32'h0,2'h0},
        '{12'h100,0,0,32'h14010001,2'h0}, '{12'h104,0,0,32'h0,2'h0},
        '{12'h108,0,0,32'h0,2'h0}, '{12'h10C,0,0,32'h00062011,2'h0},
        '{12'h0DC,0,0,32'h0,2'h2}, '{12'h0E4,1,'1,32'h800,2'h0},
        '{12'h0E8,1,'1,32'h6400,2'h0}, '{12'h0EC,1,'1,32'h0,2'h0},
        '{12'h0F0,1,'1,32'h00011FFF,2'h0}, '{12'h0F4,1,'1,32'h0,2'h0},
        '{12'h0F8,1,'1,32'h0,2'h0}, '{12'h100,1,'1,32'h14010001,2'h0},
        '{12'h108,1,'1,32'h003FF011,2'h0}, '{12'h0DC,1,'1,32'h0,2'h2}};

    pcie_port_slot_aer_regs uut (.*);

    // free-running 100 MHz clock
    always #5 aclk = ~aclk;

    // count output pulse cycles outside reset
    always @(posedge aclk) begin
        if (aresetn === 1'b1) begin
            n_note   += (dll_change_notify === 1'b1);
            n_fatal  += (err_fatal_msg === 1'b1);
            n_nonfat += (err_nonfatal_msg === 1'b1);
            n_log    += (header_log_capture === 1'b1);
        end
    end

    // masked compare, counts every call
    task automatic chk(input logic [31:0] got, exp, m);
        check_count++;
        if ((got & m) !== (exp & m)) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one write, address and data offered together
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    // one read, data taken at the rvalid edge
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // write expecting an okay answer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        axi_write(a, d, rsp);
        chk(32'(rsp), 32'h0, '1);
    endtask

    // read expecting okay and masked data
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, m);
        axi_read(a, rd, rsp);
        chk(32'(rsp), 32'h0, '1);
        chk(rd, e, m);
    endtask

    // one-cycle event: 32 poisoned in, 33 poisoned out, else error bit
    task automatic ev(input int i);
        @(posedge aclk);
        if (i == 32) poisoned_rx <= 1'b1;
        else if (i == 33) poisoned_gen <= 1'b1;
        else err_events <= 32'h1 << i;
        @(posedge aclk);
        err_events   <= '0;
        poisoned_rx  <= 1'b0;
        poisoned_gen <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // verdict and end of run
    task automatic final_report;
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the expected few hundred cycles
    initial begin
        #200000;
        err_total++;
        final_report();
    end

    // main sequence
    initial begin
        {aclk, aresetn, awaddr, araddr, wdata, err_events} = '0;
        {awvalid, wvalid, bready, arvalid, rready, command_done} = '0;
        {attn_button_pin, power_fault_pin, mrl_open_pin} = '0;
        {card_present_pin, link_layer_active_state} = '0;
        {poisoned_rx, poisoned_gen} = '0;
        {port_is_downstream, slot_implemented} = 2'b11;
        wstrb = 4'hF;
        {err_total, check_count, n_note, n_fatal, n_nonfat, n_log} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].a, rows[i].d, rsp);
                chk(32'(rsp), 32'(rows[i].r), '1);
            end
            axi_read(rows[i].a, rd, rsp);
            chk(32'(rsp), 32'(rows[i].r), '1);
            chk(rd, rows[i].exp, '1);
        end
        chk(32'({ltr_enable, obff_enable}), 32'h7, '1);
        chk(32'(autonomous_speed_disable), 32'h1, '1);
        // slot power and lock control
        wr(12'h0D8, 32'h00001C00);
        chk(32'({slot_power_off, electromech_lock_control}), 32'h3,
            '1);
        rdc(12'h0D8, 32'h00001C00, 32'h0000FFFF);
        wr(12'h0D8, 32'h00001000);
        chk(32'(slot_power_off), 32'h0, '1);
        // link active change with notification enabled, then disabled
        @(posedge aclk) link_layer_active_state <= 1'b1;
        repeat (3) @(posedge aclk);
        rdc(12'h0D0, 32'h20000000, 32'h20000000);
        rdc(12'h0D8, 32'h01001000, 32'h0100FFFF);
        chk(32'(n_note), 32'h1, '1);
        wr(12'h0D8, 32'h01000000);
        rdc(12'h0D8, 32'h0, 32'h01001000);
        @(posedge aclk) link_layer_active_state <= 1'b0;
        repeat (3) @(posedge aclk);
        rdc(12'h0D0, 32'h0, 32'h20000000);
        rdc(12'h0D8, 32'h01000000, 32'h01000000);
        chk(32'(n_note), 32'h1, '1);
        wr(12'h0D8, 32'h01000000);
        // hot-plug events latch; all but latch change clear on write one
        @(posedge aclk);
        {attn_button_pin, power_fault_pin, mrl_open_pin} <= 3'b111;
        {card_present_pin, command_done} <= 2'b11;
        @(posedge aclk) command_done <= 1'b0;
        repeat (6) @(posedge aclk);
        rdc(12'h0D8, 32'h007F0000, 32'h017F0000);
        // status bytes not enabled: flags must survive the write
        wstrb <= 4'h3;
        wr(12'h0D8, 32'h001F0000);
        wstrb <= 4'hF;
        rdc(12'h0D8, 32'h007F0000, 32'h017F0000);
        wr(12'h0D8, 32'h001F0000);
        rdc(12'h0D8, 32'h00640000, 32'h017F0000);
        @(posedge aclk) {mrl_open_pin, card_present_pin} <= 2'b00;
        repeat (6) @(posedge aclk);
        rdc(12'h0D8, 32'h000C0000, 32'h007F0000);
        @(posedge aclk) slot_implemented <= 1'b0;
        repeat (4) @(posedge aclk);
        rdc(12'h0D8, 32'h00400000, 32'h00400000);
        // upstream port: de-emphasis bits low, presence from pin
        @(posedge aclk) port_is_downstream <= 1'b0;
        repeat (4) @(posedge aclk);
        rdc(12'h0F0, 32'h0, 32'h00010040);
        rdc(12'h0D8, 32'h0, 32'h00400000);
        // uncorrectable errors, unmasked, only training error fatal
        wr(12'h108, 32'h0);
        wr(12'h10C, 32'h1);
        ev(0);
        ev(4);
        ev(32);
        ev(33);
        for (int i = 13; i < 22; i++) ev(i);
        rdc(12'h104, 32'h003FF011, '1);
        chk(32'(n_fatal), 32'd1, '1);
        chk(32'(n_nonfat), 32'd12, '1);
        chk(32'(n_log), 32'd13, '1);
        wr(12'h104, 32'h003FF011);
        rdc(12'h104, 32'h0, '1);
        // masked: still latched, nothing reported or logged
        wr(12'h108, 32'hFFFFFFFF);
        ev(0);
        ev(32);
        rdc(12'h104, 32'h00001001, '1);
        wr(12'h104, 32'h00001001);
        ev(33);
        rdc(12'h104, 32'h00001000, '1);
        chk(32'(n_fatal + n_nonfat + n_log), 32'd26, '1);
        // second reset restores defaults
        @(posedge aclk) aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(12'h10C, 32'h00062011, '1);
        rdc(12'h108, 32'h0, '1);
        final_report();
    end
endmodule // testbench
